/* File: inc/smpc_pkg.sv */
// Purpose: constants for the stop mode power controller
// Assumes: 8-bit register port, 50 MHz mclk_i
// Notes: register offsets are byte indices on the plain port
package smpc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int WAKE_OSC_HZ = 1000; // self-clocked wake source
  localparam int WAKE_OSC_CYCLES = CLK_HZ / WAKE_OSC_HZ;
  localparam logic [15:0] TICK_BASE_MS = 16'h0004;
  // register indices
  localparam logic [3:0] ADDR_SYS_OPT = 4'h0;
  localparam logic [3:0] ADDR_PWR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_TICK_CTRL = 4'h2;
  localparam logic [3:0] ADDR_DBG_CTRL = 4'h3;
  localparam logic [3:0] ADDR_CLKGEN1 = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  // field positions
  localparam int B_STOP_ALLOW = 0;
  localparam int B_PPD_SEL = 0;
  localparam int B_PPD_ACK = 1;
  localparam int B_PPD_FLAG = 2;
  localparam int B_LOWVOLT_KEEP = 3;
  localparam int B_LOWVOLT_ON = 4;
  localparam int B_TICK_FLAG = 3;
  localparam int B_TICK_ACK = 4;
  localparam int B_DBG_ALLOW = 0;
  localparam int B_OSC_KEEP = 0;
  localparam int B_ADC_ASYNC = 1;
  // reset values
  localparam logic RST_STOP_ALLOW = 1'b0;
  localparam logic RST_PPD_SEL = 1'b0;
  localparam logic RST_LOWVOLT_KEEP = 1'b0;
  localparam logic RST_LOWVOLT_ON = 1'b0;
  localparam logic [2:0] RST_TICK_SEL = 3'h0;
  localparam logic RST_DBG_ALLOW = 1'b0;
  localparam logic RST_OSC_KEEP = 1'b0;
  localparam logic RST_ADC_ASYNC = 1'b0;
  typedef enum logic [1:0] {ST_RUN, ST_DEEP, ST_RET} smpc_state_t;
endpackage

/* File: verilog/smpc_wake_tick.sv */
// Purpose: periodic wake tick from the 1 kHz wake source
// Assumes: source modelled by a divider of mclk_i
// Notes: interval is TICK_BASE_MS << select milliseconds
`timescale 1ns/1ps
`default_nettype none
module smpc_wake_tick #(
  parameter int TICK_CYCLES = smpc_pkg::WAKE_OSC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [2:0] sel_i,
  output logic tick_o,
  output logic osc_run_o
);
  initial if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
  logic [31:0] pre_reg;
  logic [15:0] ms_reg;
  wire osc_on = (sel_i != 3'h0); // select zero kills source
  wire ms_edge = osc_on && (pre_reg == 32'(TICK_CYCLES - 1));
  wire [15:0] target = smpc_pkg::TICK_BASE_MS << sel_i;
  wire ms_done = ms_edge && (ms_reg >= target - 16'h0001);
  // prescaler and interval counter
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !osc_on)
    begin
      pre_reg <= '0;
      ms_reg <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      pre_reg <= ms_edge ? '0 : pre_reg + 32'h1;
      ms_reg <= ms_done ? '0 : (ms_edge ? ms_reg + 16'h0001 : ms_reg);
      tick_o <= ms_done;
    end
    osc_run_o <= !rst_i && osc_on;
  end
  a_tick_off_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    (sel_i == 3'h0) |=> !tick_o && !osc_run_o) else $error("tick while off");
endmodule
`default_nettype wire

/* File: verilog/smpc_pin_latch.sv */
// Purpose: pin state latch for deep power-down stop
// Assumes: capture and release are one-cycle pulses
// Notes: not cleared by the power-on style wake reset
`timescale 1ns/1ps
`default_nettype none
module smpc_pin_latch #(
  parameter int PINS = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic capture_i,
  input wire logic release_i,
  input wire logic [PINS-1:0] port_out_i,
  input wire logic [PINS-1:0] port_oe_i,
  input wire logic [PINS-1:0] periph_en_i,
  input wire logic [PINS-1:0] periph_out_i,
  input wire logic [PINS-1:0] periph_oe_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic latched_o
);
  initial if (PINS < 1) $error("PINS must be positive");
  // disabled peripheral hands pin to port registers
  wire [PINS-1:0] live_out = (periph_en_i & periph_out_i) | (~periph_en_i & port_out_i);
  wire [PINS-1:0] live_oe = (periph_en_i & periph_oe_i) | (~periph_en_i & port_oe_i);
  wire latched_next = capture_i || (latched_o && !release_i);
  // hold pads while latched, else follow live values
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      latched_o <= 1'b0;
      pad_out_o <= '0;
      pad_oe_o <= '0;
    end
    else
    begin
      latched_o <= latched_next;
      pad_out_o <= latched_next ? pad_out_o : live_out;
      pad_oe_o <= latched_next ? pad_oe_o : live_oe;
    end
  end
  a_open_follows: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !latched_o && !capture_i |=> pad_out_o == $past(live_out) && pad_oe_o == $past(live_oe))
    else $error("open pin not following source");
endmodule
`default_nettype wire

/* File: verilog/smpc_top.sv */
// Purpose: stop mode power controller, mode selection and wake sequencing
// Assumes: inputs synchronous to mclk_i; stop_exec_i pulses per stop instruction
// Notes: deep wake pulses cpu_reset_o and restores register defaults
`timescale 1ns/1ps
`default_nettype none
module smpc_top #(
  parameter int PINS = 8,
  parameter int TICK_CYCLES = smpc_pkg::WAKE_OSC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic stop_exec_i,
  input wire logic reset_pin_n_i,
  input wire logic irq_pin_n_i,
  input wire logic irq_enable_i,
  input wire logic irq_active_high_i,
  input wire logic keypad_irq_i,
  input wire logic serial_rx_irq_i,
  input wire logic adc_irq_i,
  input wire logic lowvolt_irq_i,
  input wire logic debug_halt_cmd_i,
  input wire logic debug_status_cmd_i,
  input wire logic [PINS-1:0] port_out_i,
  input wire logic [PINS-1:0] port_oe_i,
  input wire logic [PINS-1:0] periph_en_i,
  input wire logic [PINS-1:0] periph_out_i,
  input wire logic [PINS-1:0] periph_oe_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o,
  output logic cpu_reset_o,
  output logic illegal_reset_o,
  output logic cpu_irq_wake_o,
  output logic debug_enter_o,
  output logic status_cmd_err_o,
  output logic deep_stop_o,
  output logic ret_stop_o,
  output logic periph_clk_en_o,
  output logic debug_clk_en_o,
  output logic core_power_on_o,
  output logic regulator_full_o,
  output logic adc_run_o,
  output logic osc_run_o,
  output logic wake_osc_run_o
);
  initial if (PINS < 1 || PINS > 64) $error("PINS out of range");

  smpc_pkg::smpc_state_t state_reg;
  smpc_pkg::smpc_state_t state_next;
  logic stop_allow_reg;
  logic ppd_sel_reg;
  logic lowvolt_keep_reg;
  logic lowvolt_on_reg;
  logic [2:0] tick_sel_reg;
  logic dbg_allow_reg;
  logic osc_keep_reg;
  logic adc_async_reg;
  logic wake_flag_reg;
  logic tick_flag_reg;
  logic illegal_seen_reg;
  logic soft_rst_reg;
  logic tick_w;
  logic latched_w;

  // register port decode
  wire wr_sys = reg_wr_i && (reg_addr_i == smpc_pkg::ADDR_SYS_OPT);
  wire wr_pwr = reg_wr_i && (reg_addr_i == smpc_pkg::ADDR_PWR_CTRL2);
  wire wr_tick = reg_wr_i && (reg_addr_i == smpc_pkg::ADDR_TICK_CTRL);
  wire wr_dbg = reg_wr_i && (reg_addr_i == smpc_pkg::ADDR_DBG_CTRL);
  wire wr_clk = reg_wr_i && (reg_addr_i == smpc_pkg::ADDR_CLKGEN1);
  wire ack_wr = wr_pwr && reg_wdata_i[smpc_pkg::B_PPD_ACK]; // writing 0 does nothing
  wire tick_ack = wr_tick && reg_wdata_i[smpc_pkg::B_TICK_ACK];
  wire regs_rst = !resetn_i || soft_rst_reg; // wake from deep restores defaults

  // stop decisions
  wire lowvolt_in_stop = lowvolt_on_reg && lowvolt_keep_reg;
  wire deep_ok = ppd_sel_reg && stop_allow_reg && !lowvolt_in_stop && !dbg_allow_reg;
  wire run_stop = (state_reg == smpc_pkg::ST_RUN) && stop_exec_i;
  wire go_illegal = run_stop && !stop_allow_reg;
  wire go_deep = run_stop && deep_ok;
  wire go_ret = run_stop && stop_allow_reg && !deep_ok;

  // wake sources
  wire irq_cfg_hit = irq_enable_i && (irq_active_high_i ? irq_pin_n_i : !irq_pin_n_i);
  wire deep_wake = !reset_pin_n_i || !irq_pin_n_i || tick_w; // irq forced low-active
  wire ret_int = irq_cfg_hit || keypad_irq_i || tick_w || serial_rx_irq_i || adc_irq_i
    || lowvolt_irq_i;
  wire in_deep = (state_reg == smpc_pkg::ST_DEEP);
  wire in_ret = (state_reg == smpc_pkg::ST_RET);
  wire in_stop = in_deep || in_ret;
  wire dbg_halt = in_ret && dbg_allow_reg && debug_halt_cmd_i;
  wire deep_exit = in_deep && deep_wake;
  wire ret_rst = in_ret && !reset_pin_n_i;
  wire ret_irq = in_ret && reset_pin_n_i && ret_int;
  wire ret_dbg = in_ret && reset_pin_n_i && !ret_int && dbg_halt;

  // mode state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      smpc_pkg::ST_RUN:
      begin
        if (go_deep)
          state_next = smpc_pkg::ST_DEEP;
        else if (go_ret)
          state_next = smpc_pkg::ST_RET;
      end
      smpc_pkg::ST_DEEP:
      begin
        if (deep_wake)
          state_next = smpc_pkg::ST_RUN;
      end
      smpc_pkg::ST_RET:
      begin
        if (!reset_pin_n_i || ret_int || dbg_halt)
          state_next = smpc_pkg::ST_RUN;
      end
      default: state_next = smpc_pkg::ST_RUN;
    endcase
  end

  // power and clock gating targets
  wire nx_deep = (state_next == smpc_pkg::ST_DEEP);
  wire nx_ret = (state_next == smpc_pkg::ST_RET);
  wire nx_stop = nx_deep || nx_ret;
  wire nx_dbg_clk = !nx_stop || dbg_allow_reg;
  wire nx_reg_full = !nx_stop || dbg_allow_reg || lowvolt_in_stop;
  wire nx_adc = !nx_stop || (nx_ret && adc_async_reg && lowvolt_in_stop);
  wire nx_osc = !nx_stop || (nx_ret && (osc_keep_reg || dbg_allow_reg));

  // read data, one cycle after the strobe
  wire [7:0] rd_sys = 8'({7'h00, stop_allow_reg});
  wire [7:0] rd_pwr = 8'({3'h0, lowvolt_on_reg, lowvolt_keep_reg, wake_flag_reg, 1'b0,
    ppd_sel_reg});
  wire [7:0] rd_tick = 8'({4'h0, tick_flag_reg, tick_sel_reg});
  wire [7:0] rd_dbg = 8'({7'h00, dbg_allow_reg});
  wire [7:0] rd_clk = 8'({6'h00, adc_async_reg, osc_keep_reg});
  wire [7:0] rd_stat = 8'({4'h0, illegal_seen_reg, latched_w, ret_stop_o, deep_stop_o});
  wire [7:0] rd_mux =
    (reg_addr_i == smpc_pkg::ADDR_SYS_OPT) ? rd_sys :
    (reg_addr_i == smpc_pkg::ADDR_PWR_CTRL2) ? rd_pwr :
    (reg_addr_i == smpc_pkg::ADDR_TICK_CTRL) ? rd_tick :
    (reg_addr_i == smpc_pkg::ADDR_DBG_CTRL) ? rd_dbg :
    (reg_addr_i == smpc_pkg::ADDR_CLKGEN1) ? rd_clk :
    (reg_addr_i == smpc_pkg::ADDR_STATUS) ? rd_stat : 8'h00;

  // software control registers, restored by deep wake
  always_ff @(posedge mclk_i)
  begin
    if (regs_rst)
    begin
      stop_allow_reg <= smpc_pkg::RST_STOP_ALLOW;
      ppd_sel_reg <= smpc_pkg::RST_PPD_SEL;
      lowvolt_keep_reg <= smpc_pkg::RST_LOWVOLT_KEEP;
      lowvolt_on_reg <= smpc_pkg::RST_LOWVOLT_ON;
      tick_sel_reg <= smpc_pkg::RST_TICK_SEL;
      dbg_allow_reg <= smpc_pkg::RST_DBG_ALLOW;
      osc_keep_reg <= smpc_pkg::RST_OSC_KEEP;
      adc_async_reg <= smpc_pkg::RST_ADC_ASYNC;
      tick_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_sys)
        stop_allow_reg <= reg_wdata_i[smpc_pkg::B_STOP_ALLOW];
      if (wr_pwr)
      begin
        ppd_sel_reg <= reg_wdata_i[smpc_pkg::B_PPD_SEL];
        lowvolt_keep_reg <= reg_wdata_i[smpc_pkg::B_LOWVOLT_KEEP];
        lowvolt_on_reg <= reg_wdata_i[smpc_pkg::B_LOWVOLT_ON];
      end
      if (wr_tick)
        tick_sel_reg <= reg_wdata_i[2:0];
      if (wr_dbg)
        dbg_allow_reg <= reg_wdata_i[smpc_pkg::B_DBG_ALLOW];
      if (wr_clk)
      begin
        osc_keep_reg <= reg_wdata_i[smpc_pkg::B_OSC_KEEP];
        adc_async_reg <= reg_wdata_i[smpc_pkg::B_ADC_ASYNC];
      end
      tick_flag_reg <= tick_w || (tick_flag_reg && !tick_ack); // set beats clear
    end
  end

  // wake flag survives the wake reset, cleared only by ack
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      wake_flag_reg <= 1'b0;
      illegal_seen_reg <= 1'b0;
    end
    else
    begin
      wake_flag_reg <= deep_exit || (wake_flag_reg && !ack_wr);
      illegal_seen_reg <= go_illegal || (illegal_seen_reg && !wr_sys);
    end
  end

  // state, pulses and registered outputs
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      state_reg <= smpc_pkg::ST_RUN;
      soft_rst_reg <= 1'b0;
      reg_rdata_o <= 8'h00;
      cpu_reset_o <= 1'b0;
      illegal_reset_o <= 1'b0;
      cpu_irq_wake_o <= 1'b0;
      debug_enter_o <= 1'b0;
      status_cmd_err_o <= 1'b0;
      deep_stop_o <= 1'b0;
      ret_stop_o <= 1'b0;
      periph_clk_en_o <= 1'b1;
      debug_clk_en_o <= 1'b1;
      core_power_on_o <= 1'b1;
      regulator_full_o <= 1'b1;
      adc_run_o <= 1'b1;
      osc_run_o <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      soft_rst_reg <= deep_exit || ret_rst;
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
      cpu_reset_o <= deep_exit || ret_rst || go_illegal;
      illegal_reset_o <= go_illegal;
      cpu_irq_wake_o <= ret_irq;
      debug_enter_o <= ret_dbg;
      status_cmd_err_o <= in_stop && debug_status_cmd_i;
      deep_stop_o <= nx_deep;
      ret_stop_o <= nx_ret;
      periph_clk_en_o <= !nx_stop;
      debug_clk_en_o <= nx_dbg_clk;
      core_power_on_o <= !nx_deep;
      regulator_full_o <= nx_reg_full;
      adc_run_o <= nx_adc;
      osc_run_o <= nx_osc;
    end
  end

  smpc_wake_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_i(regs_rst),
    .sel_i(tick_sel_reg),
    .tick_o(tick_w),
    .osc_run_o(wake_osc_run_o)
  );

  smpc_pin_latch #(
    .PINS(PINS)
  ) u_latch (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .capture_i(go_deep),
    .release_i(ack_wr),
    .port_out_i(port_out_i),
    .port_oe_i(port_oe_i),
    .periph_en_i(periph_en_i),
    .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i),
    .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o),
    .latched_o(latched_w)
  );

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_deep_entry_ok: assert property (
    go_deep |=> deep_stop_o && !core_power_on_o && !ret_stop_o)
    else $error("deep stop not entered");
  a_lowvolt_keeps_ret: assert property (
    run_stop && stop_allow_reg && lowvolt_in_stop |=> ret_stop_o && regulator_full_o)
    else $error("detector in stop did not force retention");
  a_latch_holds: assert property (
    latched_w && !ack_wr |=> latched_w && $stable(pad_out_o) && $stable(pad_oe_o))
    else $error("latched pins moved");
  a_deep_no_wake: assert property (
    in_deep && reset_pin_n_i && irq_pin_n_i && !tick_w |=> deep_stop_o)
    else $error("deep stop left without wake source");
  a_deep_wake_rst: assert property (
    deep_exit |=> cpu_reset_o && !deep_stop_o ##1 stop_allow_reg == smpc_pkg::RST_STOP_ALLOW)
    else $error("deep wake not a reset");
  a_wake_flag_hold: assert property (
    deep_exit ##1 !ack_wr |=> wake_flag_reg)
    else $error("wake flag lost");
  a_ret_entry: assert property (
    run_stop && stop_allow_reg && !ppd_sel_reg |=> ret_stop_o && !periph_clk_en_o && !latched_w)
    else $error("retention stop not entered");
  a_ret_irq_exit: assert property (
    ret_irq |=> cpu_irq_wake_o && !cpu_reset_o && !ret_stop_o)
    else $error("interrupt exit wrong");
  a_dbg_in_stop: assert property (
    (deep_stop_o || ret_stop_o) && dbg_allow_reg |-> debug_clk_en_o && regulator_full_o)
    else $error("debug lost clock in stop");
  a_dbg_no_deep: assert property (
    run_stop && dbg_allow_reg |=> !deep_stop_o)
    else $error("deep stop with debug allowed");
  a_status_err: assert property (
    in_stop && debug_status_cmd_i |=> status_cmd_err_o)
    else $error("status command error missing");
  a_periph_clk_off: assert property (
    deep_stop_o || ret_stop_o |-> !periph_clk_en_o)
    else $error("peripheral clock in stop");
  a_adc_gate: assert property (
    ret_stop_o && !(adc_async_reg && lowvolt_in_stop) |-> !adc_run_o)
    else $error("converter running in retention");
  a_osc_gate: assert property (
    ret_stop_o && !osc_keep_reg && !dbg_allow_reg |-> !osc_run_o)
    else $error("oscillator running in retention");
  a_stop_refused: assert property (
    go_illegal |=> illegal_reset_o && cpu_reset_o && !deep_stop_o && !ret_stop_o)
    else $error("disallowed stop not refused");
  a_ack_reads_zero: assert property (
    reg_rd_i && reg_addr_i == smpc_pkg::ADDR_PWR_CTRL2 |=> !reg_rdata_o[smpc_pkg::B_PPD_ACK])
    else $error("ack bit read as one");
  c_deep_cycle: cover property (go_deep ##[1:1000] deep_exit ##[1:50] ack_wr);
  c_ret_irq: cover property (go_ret ##[1:100] ret_irq);
  c_ret_dbg: cover property (go_ret ##[1:100] ret_dbg);
  c_illegal: cover property (go_illegal);
endmodule
`default_nettype wire

/* File: tb/smpc_top_test.sv */
// Purpose: self-checking bench for the stop mode power controller
// Assumes: TICK_CYCLES shortened to 4, so one select-1 tick period is 32 clocks
// Notes: inputs change by non-blocking assignment at the rising edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module smpc_top_test;
  localparam int TICKS = 4;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, stop_exec_i = 1'b0, reset_pin_n_i = 1'b1;
  logic irq_pin_n_i = 1'b1, irq_enable_i = 1'b0, irq_active_high_i = 1'b1;
  logic keypad_irq_i = 1'b0, serial_rx_irq_i = 1'b0, adc_irq_i = 1'b0, lowvolt_irq_i = 1'b0;
  logic debug_halt_cmd_i = 1'b0, debug_status_cmd_i = 1'b0;
  logic [7:0] port_out_i = 8'h00, port_oe_i = 8'hFF, periph_en_i = 8'h00;
  logic [7:0] periph_out_i = 8'h00, periph_oe_i = 8'hF0;
  logic [7:0] reg_rdata_o, pad_out_o, pad_oe_o;
  logic cpu_reset_o, illegal_reset_o, cpu_irq_wake_o, debug_enter_o, status_cmd_err_o;
  logic deep_stop_o, ret_stop_o, periph_clk_en_o, debug_clk_en_o, core_power_on_o;
  logic regulator_full_o, adc_run_o, osc_run_o, wake_osc_run_o;
  int err_count = 0;
  int tests_run = 0;
  int n;

  // 50 MHz bench clock
  always #10 mclk_i = ~mclk_i;

  smpc_top #(.PINS(8), .TICK_CYCLES(TICKS)) uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .stop_exec_i(stop_exec_i), .reset_pin_n_i(reset_pin_n_i),
    .irq_pin_n_i(irq_pin_n_i), .irq_enable_i(irq_enable_i),
    .irq_active_high_i(irq_active_high_i), .keypad_irq_i(keypad_irq_i),
    .serial_rx_irq_i(serial_rx_irq_i), .adc_irq_i(adc_irq_i), .lowvolt_irq_i(lowvolt_irq_i),
    .debug_halt_cmd_i(debug_halt_cmd_i), .debug_status_cmd_i(debug_status_cmd_i),
    .port_out_i(port_out_i), .port_oe_i(port_oe_i), .periph_en_i(periph_en_i),
    .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .cpu_reset_o(cpu_reset_o), .illegal_reset_o(illegal_reset_o),
    .cpu_irq_wake_o(cpu_irq_wake_o), .debug_enter_o(debug_enter_o),
    .status_cmd_err_o(status_cmd_err_o), .deep_stop_o(deep_stop_o), .ret_stop_o(ret_stop_o),
    .periph_clk_en_o(periph_clk_en_o), .debug_clk_en_o(debug_clk_en_o),
    .core_power_on_o(core_power_on_o), .regulator_full_o(regulator_full_o),
    .adc_run_o(adc_run_o), .osc_run_o(osc_run_o), .wake_osc_run_o(wake_osc_run_o)
  );

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // one-cycle read, data compared in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e, "read data")
  endtask

  // one stop instruction; returns just after the edge that took it
  task automatic stop_pulse();
    @(posedge mclk_i);
    stop_exec_i <= 1'b1;
    @(posedge mclk_i);
    stop_exec_i <= 1'b0;
    #1;
  endtask

  // keypad wake out of retention, no reset expected
  task automatic keypad_wake();
    @(posedge mclk_i);
    keypad_irq_i <= 1'b1;
    @(posedge mclk_i);
    keypad_irq_i <= 1'b0;
    #1;
    `CHK({cpu_irq_wake_o, cpu_reset_o, ret_stop_o}, 3'b100, "keypad wake")
  endtask

  // prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog against a hung sequence
  initial
  begin
    repeat (6000) @(posedge mclk_i);
    err_count++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 7; a++)
      rd_chk(a[3:0], 8'h00);
    // disallowed stop turns into an illegal-opcode reset
    stop_pulse();
    `CHK({illegal_reset_o, cpu_reset_o, deep_stop_o, ret_stop_o}, 4'b1100, "bad stop")
    rd_chk(smpc_pkg::ADDR_STATUS, 8'h08);
    wr(smpc_pkg::ADDR_SYS_OPT, 8'h01);
    rd_chk(smpc_pkg::ADDR_STATUS, 8'h00);
    // deep stop: pins latched, keypad and serial irqs do not wake, irq pin low does
    @(posedge mclk_i);
    port_out_i <= 8'hA5;
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h01);
    stop_pulse();
    `CHK({deep_stop_o, ret_stop_o}, 2'b10, "deep entry")
    `CHK({periph_clk_en_o, core_power_on_o, regulator_full_o, debug_clk_en_o,
      adc_run_o, osc_run_o}, 6'h00, "deep gating")
    @(posedge mclk_i);
    port_out_i <= 8'h3C;
    keypad_irq_i <= 1'b1;
    serial_rx_irq_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK({deep_stop_o, pad_out_o}, 9'h1A5, "deep hold")
    @(posedge mclk_i);
    keypad_irq_i <= 1'b0;
    serial_rx_irq_i <= 1'b0;
    irq_pin_n_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK({cpu_reset_o, illegal_reset_o, deep_stop_o}, 3'b100, "deep wake")
    @(posedge mclk_i);
    irq_pin_n_i <= 1'b1;
    rd_chk(smpc_pkg::ADDR_PWR_CTRL2, 8'h04);
    rd_chk(smpc_pkg::ADDR_SYS_OPT, 8'h00);
    @(posedge mclk_i);
    periph_en_i <= 8'h0F;
    periph_out_i <= 8'h0A;
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h00);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK(pad_out_o, 8'hA5, "zero ack")
    rd_chk(smpc_pkg::ADDR_PWR_CTRL2, 8'h04);
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h02);
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK({pad_out_o, pad_oe_o}, 16'h3AF0, "latch open")
    rd_chk(smpc_pkg::ADDR_PWR_CTRL2, 8'h00);
    // retention exits by each interrupt source except the tick
    wr(smpc_pkg::ADDR_SYS_OPT, 8'h01);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge mclk_i);
      irq_enable_i <= (k == 4);
      irq_active_high_i <= (k != 4);
      stop_pulse();
      `CHK({deep_stop_o, ret_stop_o}, 2'b01, "ret entry")
      `CHK({periph_clk_en_o, regulator_full_o, adc_run_o, osc_run_o}, 4'h0, "ret gate")
      @(posedge mclk_i);
      keypad_irq_i <= (k == 0);
      serial_rx_irq_i <= (k == 1);
      adc_irq_i <= (k == 2);
      lowvolt_irq_i <= (k == 3);
      irq_pin_n_i <= (k != 4);
      @(posedge mclk_i);
      #1;
      `CHK({cpu_irq_wake_o, cpu_reset_o, ret_stop_o}, 3'b100, "irq exit")
      @(posedge mclk_i);
      {keypad_irq_i, serial_rx_irq_i, adc_irq_i, lowvolt_irq_i} <= 4'h0;
      irq_pin_n_i <= 1'b1;
    end
    // no tick source with select zero; reset pin exit
    stop_pulse();
    repeat (100) @(posedge mclk_i);
    #1;
    `CHK({ret_stop_o, wake_osc_run_o}, 2'b10, "no tick")
    @(posedge mclk_i);
    reset_pin_n_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK({cpu_reset_o, cpu_irq_wake_o, ret_stop_o}, 3'b100, "pin exit")
    @(posedge mclk_i);
    reset_pin_n_i <= 1'b1;
    rd_chk(smpc_pkg::ADDR_SYS_OPT, 8'h00);
    // detector kept in stop forces retention and keeps converter, oscillator
    wr(smpc_pkg::ADDR_SYS_OPT, 8'h01);
    wr(smpc_pkg::ADDR_CLKGEN1, 8'h03);
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h19);
    stop_pulse();
    `CHK({deep_stop_o, ret_stop_o, regulator_full_o, adc_run_o, osc_run_o,
      periph_clk_en_o}, 6'b011110, "lvd stop")
    keypad_wake();
    // debug allowed: deep request becomes retention
    wr(smpc_pkg::ADDR_DBG_CTRL, 8'h01);
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h01);
    stop_pulse();
    `CHK({deep_stop_o, ret_stop_o, debug_clk_en_o, regulator_full_o, periph_clk_en_o},
      5'b01110, "debug stop")
    @(posedge mclk_i);
    debug_status_cmd_i <= 1'b1;
    @(posedge mclk_i);
    debug_status_cmd_i <= 1'b0;
    #1;
    `CHK({status_cmd_err_o, ret_stop_o}, 2'b11, "status cmd")
    @(posedge mclk_i);
    debug_halt_cmd_i <= 1'b1;
    @(posedge mclk_i);
    debug_halt_cmd_i <= 1'b0;
    #1;
    `CHK({debug_enter_o, ret_stop_o, cpu_reset_o}, 3'b100, "halt cmd")
    // detector on but not kept: deep stop, woken by the tick
    wr(smpc_pkg::ADDR_DBG_CTRL, 8'h00);
    wr(smpc_pkg::ADDR_TICK_CTRL, 8'h01);
    // tick wakes retention through its interrupt, no reset
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h00);
    stop_pulse();
    n = 0;
    while (cpu_irq_wake_o !== 1'b1 && n < 200)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    `CHK({cpu_irq_wake_o, cpu_reset_o, ret_stop_o}, 3'b100, "tick ret wake")
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h11);
    stop_pulse();
    `CHK({deep_stop_o, wake_osc_run_o}, 2'b11, "tick deep")
    n = 0;
    while (cpu_reset_o !== 1'b1 && n < 200)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    `CHK({cpu_reset_o, deep_stop_o}, 2'b10, "tick wake")
    rd_chk(smpc_pkg::ADDR_PWR_CTRL2, 8'h04);
    wr(smpc_pkg::ADDR_PWR_CTRL2, 8'h02);
    rd_chk(smpc_pkg::ADDR_STATUS, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
